// ==== lpti_assertions.sv ====
`timescale 1ns/10ps
`default_nettype none
module lpti_assertions #(
    parameter [15:0] DEVICE_ID = 16'h1234 // Arbitrary identification value
) (
    input wire clk_sys,
    input wire rst_b,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] cmd_addr,
    input wire [15:0] rd_data_ff,
    input wire int_out,
    input wire int_oe_b,
    input wire prox_sample_pulse,
    input wire light_sample_pulse
);
    logic [2:0] act_ff;
    wire act = light_sample_pulse | prox_sample_pulse | wr_stb | rd_stb;
    // Recent causes that may move the pin
    always @(posedge clk_sys or negedge rst_b)
        if (!rst_b)
            act_ff <= 3'h0;
        else
            act_ff <= {act_ff[1:0], act};
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    sequence s_flag_rd; rd_stb && cmd_addr == 8'h0d; endsequence
    sequence s_id_rd; rd_stb && cmd_addr == 8'h0e; endsequence
    property p_drive; int_out == 1'b0; endproperty
    property p_hold; !rd_stb |=> $stable(rd_data_ff); endproperty
    property p_id; s_id_rd |=> rd_data_ff == DEVICE_ID; endproperty
    property p_unmap; rd_stb && cmd_addr == 8'h0f |=> rd_data_ff == 16'h0000; endproperty
    property p_flag_bits; s_flag_rd |=> (rd_data_ff & 16'hccff) == 16'h0000; endproperty
    property p_light_gap; light_sample_pulse |=> !light_sample_pulse [*8]; endproperty
    property p_prox_gap; prox_sample_pulse |=> !prox_sample_pulse [*8]; endproperty
    property p_cause; $changed(int_oe_b) |-> act || act_ff != 3'h0; endproperty
    a_drive: assert property (p_drive) else $error("pin level");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_id: assert property (p_id) else $error("id value");
    a_unmap: assert property (p_unmap) else $error("unmapped read");
    a_flag_bits: assert property (p_flag_bits) else $error("flag bits");
    a_light_gap: assert property (p_light_gap) else $error("light period");
    a_prox_gap: assert property (p_prox_gap) else $error("prox period");
    a_cause: assert property (p_cause) else $error("pin moved alone");
endmodule // lpti_assertions
bind lpti_core lpti_assertions #(.DEVICE_ID(DEVICE_ID)) u_lpti_assertions (.clk_sys(clk_sys), .rst_b(rst_b),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_addr(cmd_addr), .rd_data_ff(rd_data_ff), .int_out(int_out),
    .int_oe_b(int_oe_b), .prox_sample_pulse(prox_sample_pulse), .light_sample_pulse(light_sample_pulse));
`default_nettype wire

// ==== lpti_core.v ====
`timescale 1ns/10ps
`default_nettype none
`include "lpti_regs.vh"
module lpti_core #(
    parameter integer BASE_CYC = `LPTI_BASE_CYC,
    parameter integer PROX_PERIOD_CYC = `LPTI_PROX_PERIOD_CYC,
    parameter [15:0] DEVICE_ID = 16'h1234 // Arbitrary identification value
) (
    input wire clk_sys,
    input wire rst_b,
    input wire wr_stb,
    input wire rd_stb,
    input wire [7:0] cmd_addr,
    input wire [15:0] wr_data,
    output reg [15:0] rd_data_ff,
    input wire [15:0] light_raw,
    input wire [15:0] prox_raw,
    output wire int_out,
    output wire int_oe_b,
    output wire prox_sample_pulse,
    output wire light_sample_pulse
);
    // Host-written configuration
    reg [15:0] light_conf_ff;
    reg [15:0] light_upper_ff;
    reg [15:0] light_lower_ff;
    reg [15:0] prox_conf_ff;
    reg [15:0] prox_conf3_ff;
    reg [15:0] crosstalk_ff;
    reg [15:0] prox_lower_ff;
    reg [15:0] prox_upper_ff;

    // Results and sticky flags
    reg [15:0] light_result_ff;
    reg [15:0] prox_result_ff;
    reg [15:0] flags_ff;

    // Period timers and persistence counters
    reg [31:0] light_tmr_ff;
    reg [31:0] prox_tmr_ff;
    reg [3:0] light_cnt_ff;
    reg [2:0] prox_cnt_ff;
    reg forced_pend_ff;
    reg near_state_ff;

    // Decoded from configuration
    reg [31:0] light_period;
    reg [3:0] light_need;
    reg [2:0] prox_need;
    reg [15:0] rd_mux;
    wire [2:0] light_integration_select = light_conf_ff[`LPTI_LC_IT_HI:`LPTI_LC_IT_LO];
    wire [1:0] light_persistence_count = light_conf_ff[`LPTI_LC_PERS_HI:`LPTI_LC_PERS_LO];
    wire light_irq_enable = light_conf_ff[`LPTI_LC_IRQ_EN];
    wire [1:0] prox_persistence_count = prox_conf_ff[`LPTI_PC_PERS_HI:`LPTI_PC_PERS_LO];
    wire prox_detect_mechanism = prox_conf_ff[`LPTI_PC_INTT];
    wire [1:0] prox_irq_select = prox_conf_ff[`LPTI_PC_INT_HI:`LPTI_PC_INT_LO];
    wire prox_output_mode_select = prox_conf3_ff[`LPTI_PC3_MS];
    wire forced_prox_enable = prox_conf3_ff[`LPTI_PC3_FOR];

    // Flag read strobe and period-end decodes
    wire flags_rd = rd_stb && (cmd_addr == `LPTI_CMD_FLAGS);
    wire light_done = (light_tmr_ff == 32'h00000000);
    wire prox_period_done = (prox_tmr_ff == 32'h00000000);

    // Forced mode waits for trigger
    wire prox_done = forced_prox_enable ? (forced_pend_ff && prox_period_done) : prox_period_done;
    wire [15:0] prox_corr = (prox_raw > crosstalk_ff) ? (prox_raw - crosstalk_ff) : 16'h0000;
    wire light_out = (light_raw > light_upper_ff) || (light_raw < light_lower_ff);
    wire prox_hi = prox_corr > prox_upper_ff;
    wire prox_lo = prox_corr < prox_lower_ff;
    wire light_hit = light_done && light_out && ((light_cnt_ff + 4'h1) >= light_need);
    wire prox_near_hit = prox_done && prox_hi && ((prox_cnt_ff + 3'h1) >= prox_need);
    wire prox_far_hit = prox_done && prox_lo && (near_state_ff || !prox_detect_mechanism);
    reg [15:0] set_mask;

    // Integration period, base times 1, 2, 4, 4, 8 for codes 0 to 4, 16 for codes 5 to 7
    always @*
    begin
        case (light_integration_select)
            3'h0: light_period = BASE_CYC;
            3'h1: light_period = BASE_CYC * 2;
            3'h2: light_period = BASE_CYC * 4;
            3'h4: light_period = BASE_CYC * 8;
            3'h3: light_period = BASE_CYC * 4;
            default: light_period = BASE_CYC * 16;
        endcase
        light_need = 4'h1 << light_persistence_count;
        prox_need = {1'b0, prox_persistence_count} + 3'h1;
    end

    // Flag bits to set this cycle
    always @*
    begin
        set_mask = 16'h0000;
        if (light_hit && light_irq_enable)
        begin
            set_mask[`LPTI_FLAG_ABOVE] = light_raw > light_upper_ff;
            set_mask[`LPTI_FLAG_BELOW] = light_raw < light_lower_ff;
        end
        if (prox_near_hit && prox_irq_select[0])
            set_mask[`LPTI_FLAG_NEAR] = 1'b1;
        if (prox_far_hit && prox_irq_select[1])
            set_mask[`LPTI_FLAG_FAR] = 1'b1;
    end

    // Read multiplexer over every command register
    always @*
    begin
        case (cmd_addr)
            `LPTI_CMD_LIGHT_CONF: rd_mux = light_conf_ff;
            `LPTI_CMD_LIGHT_UPPER: rd_mux = light_upper_ff;
            `LPTI_CMD_LIGHT_LOWER: rd_mux = light_lower_ff;
            `LPTI_CMD_PROX_CONF: rd_mux = prox_conf_ff;
            `LPTI_CMD_PROX_CONF3: rd_mux = prox_conf3_ff;
            `LPTI_CMD_CROSSTALK: rd_mux = crosstalk_ff;
            `LPTI_CMD_PROX_LOWER: rd_mux = prox_lower_ff;
            `LPTI_CMD_PROX_UPPER: rd_mux = prox_upper_ff;
            `LPTI_CMD_PROX_RESULT: rd_mux = prox_result_ff;
            `LPTI_CMD_LIGHT_RESULT: rd_mux = light_result_ff;
            `LPTI_CMD_FLAGS: rd_mux = flags_ff;
            `LPTI_CMD_ID: rd_mux = DEVICE_ID;
            default: rd_mux = 16'h0000;
        endcase
    end

    // Host-written configuration words
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            light_conf_ff <= `LPTI_RST_LIGHT_CONF;
            light_upper_ff <= `LPTI_RST_ZERO;
            light_lower_ff <= `LPTI_RST_ZERO;
            prox_conf_ff <= `LPTI_RST_PROX_CONF;
            prox_conf3_ff <= `LPTI_RST_ZERO;
            crosstalk_ff <= `LPTI_RST_ZERO;
            prox_lower_ff <= `LPTI_RST_ZERO;
            prox_upper_ff <= `LPTI_RST_ZERO;
        end
        else if (wr_stb)
        begin
            case (cmd_addr)
                `LPTI_CMD_LIGHT_CONF: light_conf_ff <= wr_data;
                `LPTI_CMD_LIGHT_UPPER: light_upper_ff <= wr_data;
                `LPTI_CMD_LIGHT_LOWER: light_lower_ff <= wr_data;
                `LPTI_CMD_PROX_CONF: prox_conf_ff <= wr_data;
                `LPTI_CMD_PROX_CONF3: prox_conf3_ff <= wr_data & ~(16'h0001 << `LPTI_PC3_TRIG);
                `LPTI_CMD_CROSSTALK: crosstalk_ff <= wr_data;
                `LPTI_CMD_PROX_LOWER: prox_lower_ff <= wr_data;
                `LPTI_CMD_PROX_UPPER: prox_upper_ff <= wr_data;
                default: ;
            endcase
        end
    end

    // Registered read data, holds until the next read
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rd_data_ff <= `LPTI_RST_ZERO;
        end
        else if (rd_stb)
        begin
            rd_data_ff <= rd_mux;
        end
    end

    // One forced measurement pending per trigger write
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            forced_pend_ff <= 1'b0;
        end
        else if (wr_stb && cmd_addr == `LPTI_CMD_PROX_CONF3 && wr_data[`LPTI_PC3_TRIG])
        begin
            forced_pend_ff <= 1'b1;
        end
        else if (prox_done && forced_prox_enable)
        begin
            forced_pend_ff <= 1'b0;
        end
    end

    // Light integration timer, reloads at each period end
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            light_tmr_ff <= 32'h00000000;
        end
        else if (light_done)
        begin
            light_tmr_ff <= light_period - 32'h1;
        end
        else
        begin
            light_tmr_ff <= light_tmr_ff - 32'h1;
        end
    end

    // Proximity period timer; parks at zero in forced standby
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prox_tmr_ff <= 32'h00000000;
        end
        else if (!prox_period_done)
        begin
            prox_tmr_ff <= prox_tmr_ff - 32'h1;
        end
        else if (!forced_prox_enable || forced_pend_ff)
        begin
            prox_tmr_ff <= PROX_PERIOD_CYC - 1;
        end
        else
        begin
            prox_tmr_ff <= prox_tmr_ff;
        end
    end

    // Light result and persistence count
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            light_result_ff <= `LPTI_RST_ZERO;
            light_cnt_ff <= 4'h0;
        end
        else if (light_done)
        begin
            light_result_ff <= light_raw;
            if (!light_out || light_hit)
            begin
                light_cnt_ff <= 4'h0;
            end
            else
            begin
                light_cnt_ff <= light_cnt_ff + 4'h1;
            end
        end
    end

    // Proximity result, persistence count and near state
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            prox_result_ff <= `LPTI_RST_ZERO;
            prox_cnt_ff <= 3'h0;
            near_state_ff <= 1'b0;
        end
        else if (prox_done)
        begin
            prox_result_ff <= prox_corr;
            if (!prox_hi || prox_near_hit)
            begin
                prox_cnt_ff <= 3'h0;
            end
            else
            begin
                prox_cnt_ff <= prox_cnt_ff + 3'h1;
            end
            if (prox_near_hit)
            begin
                near_state_ff <= 1'b1;
            end
            else if (prox_lo)
            begin
                near_state_ff <= 1'b0;
            end
        end
    end

    // Sticky flags; a set in the read cycle wins over the clear
    always @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flags_ff <= `LPTI_RST_ZERO;
        end
        else if (flags_rd)
        begin
            flags_ff <= set_mask;
        end
        else
        begin
            flags_ff <= flags_ff | set_mask;
        end
    end

    assign prox_sample_pulse = prox_done;
    assign light_sample_pulse = light_done;
    // Pin low: logic mode tracks near state, else any flag
    assign int_out = 1'b0;
    assign int_oe_b = prox_output_mode_select ? !near_state_ff : (flags_ff == 16'h0000);
endmodule // lpti_core
`default_nettype wire

// ==== lpti_core_bench.sv ====
`timescale 1ns/10ps
`default_nettype none
module lpti_core_bench;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic [15:0] light_raw = 16'h0180;
    logic [15:0] prox_raw = 16'h0000;
    wire wr_stb, rd_stb, int_out, int_oe_b, int_pin, prox_sample_pulse, light_sample_pulse;
    wire [7:0] cmd_addr;
    wire [15:0] wr_data, rd_data_ff;
    int miscompares = 0;
    int comparisons = 0;
    int prox_cnt = 0;
    int base;
    logic [39:0] rows [0:9] = '{40'h01_0200_0200, 40'h02_0100_0100, 40'h05_0010_0010, 40'h06_0040_0040,
        40'h07_0080_0080, 40'h04_000c_0008, 40'h03_0308_0308, 40'h00_0006_0006, 40'h0b_abcd_0180,
        40'h0f_1234_0000};
    logic [16:0] lm [0:2] = '{17'h00200, 17'h000c0, 17'h00041};
    lpti_core #(.BASE_CYC(20), .PROX_PERIOD_CYC(10)) u_lpti_core (.clk_sys(clk_sys), .rst_b(rst_b),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_addr(cmd_addr), .wr_data(wr_data), .rd_data_ff(rd_data_ff),
        .light_raw(light_raw), .prox_raw(prox_raw), .int_out(int_out), .int_oe_b(int_oe_b),
        .prox_sample_pulse(prox_sample_pulse), .light_sample_pulse(light_sample_pulse));
    lpti_host u_lpti_host (.clk_sys(clk_sys), .int_out(int_out), .int_oe_b(int_oe_b), .int_pin(int_pin),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .cmd_addr(cmd_addr), .wr_data(wr_data));
    initial forever #25 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (prox_sample_pulse) prox_cnt <= prox_cnt + 1;
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            miscompares++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        u_lpti_host.xfer(1'b0, a, 16'h0000);
        @(negedge clk_sys);
        check(rd_data_ff, e);
    endtask
    task automatic pin(input logic e);
        check({15'h0000, int_pin}, {15'h0000, e});
    endtask
    task automatic print_verdict;
        if (miscompares == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (3000) @(posedge clk_sys);
        miscompares++;
        print_verdict();
    end
    initial
    begin
        repeat (10) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd(8'h00, 16'h0001);
        rd(8'h0d, 16'h0000);
        rd(8'h0e, 16'h1234);
        foreach (rows[i])
        begin
            u_lpti_host.xfer(1'b1, rows[i][39:32], rows[i][31:16]);
            rd(rows[i][39:32], rows[i][15:0]);
        end
        // Above, inside, above, above with a count of two
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk_sys) light_raw <= (i == 1) ? 16'h0180 : 16'h0300;
            @(posedge light_sample_pulse);
            repeat (3) @(negedge clk_sys);
            if (i > 1) pin(i == 2);
        end
        rd(8'h0b, 16'h0300);
        rd(8'h0d, 16'h1000);
        pin(1'b1);
        u_lpti_host.xfer(1'b1, 8'h00, 16'h0000);
        base = prox_cnt;
        @(posedge clk_sys) prox_raw <= 16'h0100;
        repeat (30) @(negedge clk_sys);
        check(16'(prox_cnt - base), 16'h0000);
        u_lpti_host.xfer(1'b1, 8'h04, 16'h000c);
        repeat (30) @(negedge clk_sys);
        check(16'(prox_cnt - base), 16'h0001);
        pin(1'b0);
        rd(8'h08, 16'h00f0);
        rd(8'h0d, 16'h0200);
        foreach (lm[i])
        begin
            @(posedge clk_sys) prox_raw <= lm[i][16:1];
            u_lpti_host.xfer(1'b1, 8'h04, 16'h004c);
            repeat (30) @(negedge clk_sys);
            pin(lm[i][0]);
        end
        print_verdict();
    end
endmodule // lpti_core_bench
`default_nettype wire

// ==== lpti_host.sv ====
`timescale 1ns/10ps
`default_nettype none
module lpti_host (
    input wire logic clk_sys,
    input wire logic int_out,
    input wire logic int_oe_b,
    output logic int_pin,
    output logic wr_stb = 1'b0,
    output logic rd_stb = 1'b0,
    output logic [7:0] cmd_addr = 8'h00,
    output logic [15:0] wr_data = 16'h0000
);
    // Pull-up holds the line high when released
    assign int_pin = int_oe_b ? 1'b1 : int_out;
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        {wr_stb, rd_stb, cmd_addr, wr_data} <= {w, !w, a, d};
        @(posedge clk_sys);
        {wr_stb, rd_stb, wr_data} <= {2'b00, ~d};
    endtask
endmodule // lpti_host
`default_nettype wire

// ==== lpti_regs.vh ====
// Operation
// - Light limits are sixteen bits, two bytes
// - Light outside window raises interrupt when enabled
// - Integration select codes pick period length
// - Count resolution halves as period doubles
// - Light persistence is one, two, four, eight
// - Proximity persistence is one to four
// - Forced mode measures once per trigger
// - All command registers read back contents
// - Light result is low and high byte
// - Subtract crosstalk offset from raw proximity
// - Both sources share one active-low pin
// - Registers stay accessible while pin asserted
// - Any flag rising drives pin low
// - Reading flags clears them, pin releases
// - Logic mode pin tracks near and far
// - Logic mode pin serves proximity only
// - Between thresholds proximity state is kept
// - Registers hold defaults after reset
// - Flag bits: near1, far0, above4, below5
`ifndef LPTI_REGS_VH
`define LPTI_REGS_VH
`define LPTI_CMD_LIGHT_CONF 8'h00
`define LPTI_CMD_LIGHT_UPPER 8'h01
`define LPTI_CMD_LIGHT_LOWER 8'h02
`define LPTI_CMD_PROX_CONF 8'h03
`define LPTI_CMD_PROX_CONF3 8'h04
`define LPTI_CMD_CROSSTALK 8'h05
`define LPTI_CMD_PROX_LOWER 8'h06
`define LPTI_CMD_PROX_UPPER 8'h07
`define LPTI_CMD_PROX_RESULT 8'h08
`define LPTI_CMD_LIGHT_RESULT 8'h0b
`define LPTI_CMD_FLAGS 8'h0d
`define LPTI_CMD_ID 8'h0e
`define LPTI_LC_IT_HI 7
`define LPTI_LC_IT_LO 5
`define LPTI_LC_PERS_HI 3
`define LPTI_LC_PERS_LO 2
`define LPTI_LC_IRQ_EN 1
`define LPTI_PC_PERS_HI 5
`define LPTI_PC_PERS_LO 4
`define LPTI_PC_INTT 3
`define LPTI_PC_INT_HI 9
`define LPTI_PC_INT_LO 8
`define LPTI_PC3_MS 6
`define LPTI_PC3_FOR 3
`define LPTI_PC3_TRIG 2
`define LPTI_FLAG_FAR 8
`define LPTI_FLAG_NEAR 9
`define LPTI_FLAG_ABOVE 12
`define LPTI_FLAG_BELOW 13
`define LPTI_RST_LIGHT_CONF 16'h0001
`define LPTI_RST_PROX_CONF 16'h0000
`define LPTI_RST_ZERO 16'h0000
`define LPTI_RST_UPPER 16'hffff
`define LPTI_IT_BASE_MS 50
`define LPTI_CLK_HZ 20000000
`define LPTI_BASE_CYC ((`LPTI_IT_BASE_MS * `LPTI_CLK_HZ) / 1000)
`define LPTI_PROX_PERIOD_CYC 100000
`endif
